// file: include/branch_bit_pkg.sv
// Constants, types and carriers for the branch and bit-operation execute unit.
// Assumes a 4-phase instruction cycle and a Wishbone classic register master.
package branch_bit_pkg;
  localparam int          PC_W          = 21;
  localparam logic [7:0]  OPC_NONZERO   = 8'he1;
  localparam logic [7:0]  OPC_OVERFLOW  = 8'he4;
  localparam logic [4:0]  OPC_ALWAYS    = 5'h1a;
  localparam logic [3:0]  NIB_FORCE     = 4'h8;
  localparam logic [3:0]  NIB_INVERT    = 4'h7;
  localparam logic [3:0]  NIB_SKIP_CLR  = 4'hb;
  localparam logic [3:0]  NIB_SKIP_ONE  = 4'ha;
  localparam int          NIB_HI        = 15;
  localparam int          NIB_LO        = 12;
  localparam int          BITN_HI       = 11;
  localparam int          BITN_LO       = 9;
  localparam int          ACC_POS       = 8;
  localparam logic [7:0]  IDX_LIMIT     = 8'h5f;
  localparam logic [3:0]  ACCESS_HIGH   = 4'hf;
  localparam logic [7:0]  ADR_CTRL      = 8'h00;
  localparam logic [7:0]  ADR_BANK      = 8'h04;
  localparam logic [7:0]  ADR_IDX_BASE  = 8'h08;
  localparam logic [7:0]  ADR_PC        = 8'h0c;
  localparam logic [7:0]  ADR_STAT      = 8'h10;
  localparam int          CTRL_RUN      = 0;
  localparam int          CTRL_EXT      = 1;
  localparam logic        RUN_RST       = 1'b0;
  localparam logic        EXT_RST       = 1'b0;
  localparam logic [3:0]  BANK_RST      = 4'h0;
  localparam logic [11:0] IDX_BASE_RST  = 12'h000;
  localparam logic [PC_W-1:0] PC_RST    = '0;
  localparam logic [1:0]  PH_Q1         = 2'h0;
  localparam logic [1:0]  PH_Q2         = 2'h1;
  localparam logic [1:0]  PH_Q3         = 2'h2;
  localparam logic [1:0]  PH_Q4         = 2'h3;

  typedef enum logic [2:0] {
    idle_slot, branch_nonzero_op, branch_overflow_op, branch_always_op,
    bit_force_one_op, bit_invert_op, test_skip_when_clear_op, test_skip_when_one_op
  } op_e;

  typedef enum logic {run_slot, flush_slot} mode_e;

  typedef struct packed {
    logic        re;
    logic        we;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } mem_req_s;

  typedef struct packed {
    logic [1:0]      phase;
    mode_e           mode;
    logic [1:0]      flush_left;
    op_e             op;
    logic [2:0]      bitn;
    logic            acc;
    logic [7:0]      fadr;
    logic [10:0]     offs;
    logic            taken;
    logic [PC_W-1:0] pc;
    mem_req_s        mem;
    logic            run;
    logic            ext;
    logic [3:0]      bank;
    logic [11:0]     idx_base;
    logic            ack;
    logic [31:0]     rdata;
  } state_s;
endpackage

// file: verilog/branch_and_bit_op_execute.sv
// Execute unit for relative branches and single-bit file-register operations.
// Assumes fetch presents the instruction word in Q1 and memory answers reads in Q2.
module branch_and_bit_op_execute
  import branch_bit_pkg::*;
(
  input  wire logic            mclk_i,
  input  wire logic            rst_b_i,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [7:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  input  wire logic [15:0]     instr_i,
  input  wire logic            next_two_word_i,
  input  wire logic            zero_i,
  input  wire logic            ovf_i,
  input  wire logic [7:0]      mem_rdata_i,
  output mem_req_s             mem_o,
  output logic      [PC_W-1:0] pc_o,
  output logic                 flush_o,
  output logic      [1:0]      phase_o
);
  state_s          s_q;
  state_s          s_d;
  logic [PC_W-1:0] tgt;

  function automatic op_e decode(input logic [15:0] w);
    if (w[15:8] == OPC_NONZERO) return branch_nonzero_op;
    if (w[15:8] == OPC_OVERFLOW) return branch_overflow_op;
    if (w[15:11] == OPC_ALWAYS) return branch_always_op;
    case (w[NIB_HI:NIB_LO])
      NIB_FORCE:    return bit_force_one_op;
      NIB_INVERT:   return bit_invert_op;
      NIB_SKIP_CLR: return test_skip_when_clear_op;
      NIB_SKIP_ONE: return test_skip_when_one_op;
      default:      return idle_slot;
    endcase
  endfunction

  function automatic logic is_bit(input op_e o);
    return o inside {bit_force_one_op, bit_invert_op,
                     test_skip_when_clear_op, test_skip_when_one_op};
  endfunction

  function automatic logic is_branch(input op_e o);
    return o inside {branch_nonzero_op, branch_overflow_op, branch_always_op};
  endfunction

  function automatic logic [11:0] eff_addr(input logic acc, input logic [7:0] f,
                                          input logic ext, input logic [3:0] bank,
                                          input logic [11:0] base);
    if (acc) return {bank, f};
    if (ext && f <= IDX_LIMIT) return base + {4'h0, f};
    if (f <= IDX_LIMIT) return {4'h0, f};
    return {ACCESS_HIGH, f};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  // Offset is doubled and sign-extended to the PC width here
  assign tgt = s_q.pc + PC_W'(2) + {{(PC_W-12){s_q.offs[10]}}, s_q.offs, 1'b0};

  always_comb begin
    logic [31:0] wv;
    logic [7:0]  mask;
    logic        hit;
    wv   = '0;
    mask = 8'h01 << s_q.bitn;
    hit  = |(mem_rdata_i & mask);
    s_d  = s_q;
    s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
    if (s_d.ack) begin
      case (wb_adr_i)
        ADR_CTRL:     s_d.rdata = 32'({s_q.ext, s_q.run});
        ADR_BANK:     s_d.rdata = 32'(s_q.bank);
        ADR_IDX_BASE: s_d.rdata = 32'(s_q.idx_base);
        ADR_PC:       s_d.rdata = 32'(s_q.pc);
        ADR_STAT:     s_d.rdata = 32'({s_q.flush_left, s_q.mode, s_q.phase});
        default:      s_d.rdata = '0;
      endcase
    end
    // Write lands on the edge at which the master samples ack
    if (wb_cyc_i && wb_stb_i && wb_we_i && s_q.ack) begin
      wv = merge(s_q.rdata, wb_dat_i, wb_sel_i);
      case (wb_adr_i)
        ADR_CTRL: begin
          s_d.run = wv[CTRL_RUN];
          s_d.ext = wv[CTRL_EXT];
        end
        ADR_BANK:     s_d.bank = wv[3:0];
        ADR_IDX_BASE: s_d.idx_base = wv[11:0];
        default:      ;
      endcase
    end
    if (s_q.run) begin
      s_d.phase = s_q.phase + 2'd1;
      case (s_q.phase)
        PH_Q1: begin
          // Slot after a taken branch or skip runs as idle
          s_d.op    = (s_q.mode == run_slot) ? decode(instr_i) : idle_slot;
          s_d.bitn  = instr_i[BITN_HI:BITN_LO];
          s_d.acc   = instr_i[ACC_POS];
          s_d.fadr  = instr_i[7:0];
          s_d.offs  = (s_d.op == branch_always_op) ? instr_i[10:0]
                                                   : {{3{instr_i[7]}}, instr_i[7:0]};
          s_d.mem.addr = eff_addr(instr_i[ACC_POS], instr_i[7:0], s_q.ext, s_q.bank,
                                  s_q.idx_base);
          s_d.mem.re = is_bit(s_d.op);
          s_d.taken  = 1'b0;
        end
        PH_Q2: begin
          s_d.mem.re = 1'b0;
          case (s_q.op)
            branch_nonzero_op:       s_d.taken = !zero_i;
            branch_overflow_op:      s_d.taken = ovf_i;
            branch_always_op:        s_d.taken = 1'b1;
            bit_force_one_op:        s_d.mem.wdata = mem_rdata_i | mask;
            bit_invert_op:           s_d.mem.wdata = mem_rdata_i ^ mask;
            test_skip_when_clear_op: s_d.taken = !hit;
            test_skip_when_one_op:   s_d.taken = hit;
            default:                 s_d.taken = 1'b0;
          endcase
        end
        PH_Q3: s_d.mem.we = s_q.op inside {bit_force_one_op, bit_invert_op};
        PH_Q4: begin
          s_d.mem.we = 1'b0;
          s_d.pc = (s_q.taken && is_branch(s_q.op)) ? tgt : s_q.pc + PC_W'(2);
          if (s_q.mode == flush_slot) begin
            s_d.flush_left = s_q.flush_left - 2'd1;
            if (s_q.flush_left == 2'd1) s_d.mode = run_slot;
          end else if (s_q.taken) begin
            s_d.mode = flush_slot;
            s_d.flush_left = (!is_branch(s_q.op) && next_two_word_i) ? 2'd2
                                                                      : 2'd1;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '{phase: PH_Q1, mode: run_slot, flush_left: 2'd0, op: idle_slot, bitn: 3'h0,
               acc: 1'b0, fadr: 8'h00, offs: 11'h000, taken: 1'b0, pc: PC_RST,
               mem: '0, run: RUN_RST, ext: EXT_RST, bank: BANK_RST,
               idx_base: IDX_BASE_RST, ack: 1'b0, rdata: 32'h0000_0000};
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o = s_q.rdata;
  assign wb_ack_o = s_q.ack;
  assign mem_o    = s_q.mem;
  assign pc_o     = s_q.pc;
  assign flush_o  = (s_q.mode == flush_slot);
  assign phase_o  = s_q.phase;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i || !s_q.run);

  nonzero_target_a: assert property (
    s_q.phase == PH_Q4 && s_q.op == branch_nonzero_op && s_q.taken |=> s_q.pc == $past(tgt))
    else $error("nonzero branch target wrong");
  nonzero_cond_a: assert property (
    s_q.phase == PH_Q3 && s_q.op == branch_nonzero_op |-> s_q.taken == !$past(zero_i))
    else $error("nonzero branch condition wrong");
  overflow_cond_a: assert property (
    s_q.phase == PH_Q3 && s_q.op == branch_overflow_op |-> s_q.taken == $past(ovf_i))
    else $error("overflow branch condition wrong");
  taken_flush_a: assert property (
    s_q.phase == PH_Q4 && is_branch(s_q.op) && s_q.taken && s_q.mode == run_slot
    |=> (flush_o && s_q.flush_left == 2'd1)[*4] ##1 !flush_o)
    else $error("taken branch flush length wrong");
  untaken_run_a: assert property (
    s_q.phase == PH_Q4 && s_q.mode == run_slot && !s_q.taken
    |=> !flush_o && s_q.pc == $past(s_q.pc) + PC_W'(2))
    else $error("untaken op flushed or pc wrong");
  always_target_a: assert property (
    s_q.phase == PH_Q4 && s_q.op == branch_always_op |-> s_q.taken ##1 s_q.pc == $past(tgt))
    else $error("unconditional branch not taken");
  bit_write_a: assert property (
    s_q.phase == PH_Q4 && s_q.op inside {bit_force_one_op, bit_invert_op}
    |-> mem_o.we && mem_o.wdata == (s_q.op == bit_force_one_op ?
        ($past(mem_rdata_i, 2) | (8'h01 << s_q.bitn)) :
        ($past(mem_rdata_i, 2) ^ (8'h01 << s_q.bitn))))
    else $error("bit write data wrong");
  skip_len_a: assert property (
    s_q.phase == PH_Q4 && s_q.mode == run_slot && s_q.taken && is_bit(s_q.op)
    |=> flush_o && s_q.flush_left == ($past(next_two_word_i) ? 2'd2 : 2'd1))
    else $error("skip slot count wrong");
  skip_one_a: assert property (
    s_q.phase == PH_Q3 && s_q.op == test_skip_when_one_op
    |-> s_q.taken == $past(mem_rdata_i[s_q.bitn]))
    else $error("skip on one condition wrong");
  bank_addr_a: assert property (
    s_q.phase == PH_Q2 && is_bit(s_q.op)
    |-> mem_o.re && mem_o.addr == (s_q.acc ? {s_q.bank, s_q.fadr}
      : (s_q.fadr <= IDX_LIMIT ? (s_q.ext ? s_q.idx_base + {4'h0, s_q.fadr} : {4'h0, s_q.fadr})
      : {ACCESS_HIGH, s_q.fadr})))
    else $error("file address wrong");
  fields_a: assert property (
    s_q.phase == PH_Q2 && s_q.op != idle_slot |-> s_q.bitn == $past(instr_i[BITN_HI:BITN_LO]))
    else $error("bit number field wrong");

  taken_nonzero_c: cover property (s_q.phase == PH_Q4 && s_q.op == branch_nonzero_op && s_q.taken);
  long_skip_c:     cover property (s_q.mode == flush_slot && s_q.flush_left == 2'd2);
  invert_c:        cover property (s_q.phase == PH_Q4 && s_q.op == bit_invert_op);
  indexed_c:       cover property (s_q.phase == PH_Q2 && is_bit(s_q.op) && s_q.ext && !s_q.acc);
endmodule

// file: tb/tb_branch_and_bit_op_execute.sv
// Self-checking bench for the branch and bit-operation execute unit.
// Drives Wishbone and pipe inputs itself; memory read data is a per-op constant.
module tb_branch_and_bit_op_execute
  import branch_bit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end

  logic            mclk_i      = 1'b0;
  logic            rst_b_i     = 1'b0;
  logic            cyc         = 1'b0;
  logic            stb         = 1'b0;
  logic            we          = 1'b0;
  logic [7:0]      adr         = 8'h0;
  logic [31:0]     wdat        = 32'h0;
  logic [15:0]     instr       = 16'h0;
  logic            z           = 1'b0;
  logic            v           = 1'b0;
  logic            tw          = 1'b0;
  logic [7:0]      rd          = 8'h0;
  logic [31:0]     dat_o;
  logic            ack;
  mem_req_s        mem_o;
  logic [PC_W-1:0] pc_o;
  logic            flush_o;
  logic [1:0]      phase_o;
  logic [31:0]     r;
  int              fail_count  = 0;
  int              check_count = 0;

  branch_and_bit_op_execute uut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .instr_i(instr), .next_two_word_i(tw), .zero_i(z), .ovf_i(v), .mem_rdata_i(rd),
    .mem_o(mem_o), .pc_o(pc_o), .flush_o(flush_o), .phase_o(phase_o)
  );

  initial begin
    forever #25 mclk_i = ~mclk_i;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge mclk_i); while (ack !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK("register read", e, r)
  endtask

  function automatic logic [PC_W-1:0] dl(input int n);
    return PC_W'(2 + 2 * n);
  endfunction

  // One instruction slot: f = {zero, overflow, two-word next}, rw = {re, we} expected
  task automatic op(input logic [15:0] w, input logic [2:0] f, input logic [7:0] d,
                    input logic [1:0] rw, input logic [11:0] ea, input logic [7:0] ewd,
                    input logic [PC_W-1:0] dpc, input logic [1:0] fl);
    logic [PC_W-1:0] pc0;
    do @(negedge mclk_i); while (!(phase_o === PH_Q4 && flush_o === 1'b0));
    @(posedge mclk_i);
    instr <= w;
    {z, v, tw} <= f;
    rd <= d;
    @(negedge mclk_i);
    pc0 = pc_o;
    @(posedge mclk_i);
    instr <= 16'h0;
    @(negedge mclk_i);
    `CHK("phase", PH_Q2, phase_o)
    `CHK("read strobe", rw[1], mem_o.re)
    if (rw[1]) `CHK("address", ea, mem_o.addr)
    repeat (2) @(negedge mclk_i);
    `CHK("write strobe", rw[0], mem_o.we)
    if (rw[0]) `CHK("write data", ewd, mem_o.wdata)
    @(negedge mclk_i);
    `CHK("pc", pc0 + dpc, pc_o)
    `CHK("flush first", fl[0], flush_o)
    repeat (4) @(negedge mclk_i);
    `CHK("flush second", fl[1], flush_o)
  endtask

  initial begin
    repeat (5000) @(posedge mclk_i);
    fail_count++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rdc(ADR_CTRL, 32'({EXT_RST, RUN_RST}));
    rdc(ADR_BANK, 32'(BANK_RST));
    rdc(ADR_IDX_BASE, 32'(IDX_BASE_RST));
    rdc(ADR_STAT, 32'h0);
    rdc(8'h20, 32'h0);
    wb(1'b1, ADR_PC, 32'h0000_0abc);
    rdc(ADR_PC, 32'(PC_RST));
    wb(1'b1, ADR_BANK, 32'h5);
    rdc(ADR_BANK, 32'h5);
    wb(1'b1, ADR_IDX_BASE, 32'h123);
    rdc(ADR_IDX_BASE, 32'h123);
    wb(1'b1, ADR_CTRL, 32'h1);
    op({OPC_NONZERO, 8'h80}, 3'b000, 8'h0, 2'b00, 12'h0, 8'h0, dl(-128), 2'b01);
    op({OPC_NONZERO, 8'h05}, 3'b100, 8'h0, 2'b00, 12'h0, 8'h0, dl(0), 2'b00);
    op({OPC_OVERFLOW, 8'h7f}, 3'b010, 8'h0, 2'b00, 12'h0, 8'h0, dl(127), 2'b01);
    op({OPC_OVERFLOW, 8'h7f}, 3'b100, 8'h0, 2'b00, 12'h0, 8'h0, dl(0), 2'b00);
    op({OPC_ALWAYS, 11'h400}, 3'b100, 8'h0, 2'b00, 12'h0, 8'h0, dl(-1024), 2'b01);
    op({OPC_ALWAYS, 11'h3ff}, 3'b010, 8'h0, 2'b00, 12'h0, 8'h0, dl(1023), 2'b01);
    op({NIB_FORCE, 3'd3, 1'b0, 8'h5f}, 3'b0, 8'h00, 2'b11, 12'h05f, 8'h08, dl(0),
       2'b00);
    op({NIB_INVERT, 3'd7, 1'b0, 8'h60}, 3'b0, 8'hff, 2'b11, 12'hf60, 8'h7f, dl(0),
       2'b00);
    op({NIB_FORCE, 3'd0, 1'b1, 8'h12}, 3'b0, 8'h80, 2'b11, 12'h512, 8'h81, dl(0),
       2'b00);
    op({NIB_INVERT, 3'd1, 1'b1, 8'hff}, 3'b0, 8'h02, 2'b11, 12'h5ff, 8'h00, dl(0),
       2'b00);
    op({NIB_SKIP_CLR, 3'd2, 1'b0, 8'h10}, 3'b0, 8'hfb, 2'b10, 12'h010, 8'h0, dl(0),
       2'b01);
    op({NIB_SKIP_CLR, 3'd2, 1'b0, 8'h10}, 3'b1, 8'hfb, 2'b10, 12'h010, 8'h0, dl(0),
       2'b11);
    op({NIB_SKIP_CLR, 3'd2, 1'b0, 8'h10}, 3'b0, 8'h04, 2'b10, 12'h010, 8'h0, dl(0),
       2'b00);
    op({NIB_SKIP_ONE, 3'd5, 1'b1, 8'h20}, 3'b0, 8'h20, 2'b10, 12'h520, 8'h0, dl(0),
       2'b01);
    op({NIB_SKIP_ONE, 3'd5, 1'b1, 8'h20}, 3'b0, 8'hdf, 2'b10, 12'h520, 8'h0, dl(0),
       2'b00);
    op({NIB_SKIP_ONE, 3'd5, 1'b1, 8'h20}, 3'b1, 8'h20, 2'b10, 12'h520, 8'h0, dl(0),
       2'b11);
    wb(1'b1, ADR_CTRL, 32'h3);
    op({NIB_FORCE, 3'd4, 1'b0, 8'h5f}, 3'b0, 8'h00, 2'b11, 12'h182, 8'h10, dl(0),
       2'b00);
    op({NIB_FORCE, 3'd4, 1'b0, 8'h60}, 3'b0, 8'h00, 2'b11, 12'hf60, 8'h10, dl(0),
       2'b00);
    op({NIB_FORCE, 3'd4, 1'b1, 8'h5f}, 3'b0, 8'h00, 2'b11, 12'h55f, 8'h10, dl(0),
       2'b00);
    // Reset in mid-run must stop the pipe and restore the control, PC and status registers
    @(posedge mclk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rdc(ADR_CTRL, 32'({EXT_RST, RUN_RST}));
    rdc(ADR_PC, 32'(PC_RST));
    rdc(ADR_STAT, 32'h0);
    conclude();
  end
endmodule
